// file: logic/sptx_pkg.sv
// shared constants for the serial transmitter block
package sptx_pkg;
  localparam int REG_AW = 9;
  localparam logic [8:0] ADDR_RX_WORD = 9'h018;
  localparam logic [8:0] ADDR_TX_WORD = 9'h030;
  localparam logic [8:0] ADDR_BAUD = 9'h032;
  localparam logic [8:0] ADDR_CTRL = 9'h09E;
  localparam int BIT_SETCLR = 15;
  localparam int BIT_BREAK = 11;
  localparam int BIT_NINE = 15;
  localparam int BIT_RX_OVERRUN = 15;
  localparam int BIT_RBF = 14;
  localparam int BIT_TBE = 13;
  localparam int BIT_TX_SHIFTER_EMPTY = 12;
  localparam int BIT_RXD = 11;
  localparam int BIT_RX8 = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam int BAUD_W = 15;
  typedef enum logic [1:0] {SPTX_IDLE, SPTX_START, SPTX_SHIFT} sptx_state_t;
endpackage

// file: logic/sptx_tick_if.sv
// divisor and tick carrier between top and bit timer
`timescale 1ns/1ns
interface sptx_tick_if;
  logic [14:0] divisor;
  logic restart;
  logic tick;
  modport timer (input divisor, input restart, output tick);
  modport user (output divisor, output restart, input tick);
endinterface

// file: logic/sptx_bit_timer.sv
// bit interval timer: one tick every divisor+1 colour clocks
`timescale 1ns/1ns
module sptx_bit_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing carrier
  sptx_tick_if.timer tk
);
  logic [14:0] cnt_r;
  logic [14:0] cnt_nxt;
  wire logic at_end = (cnt_r >= tk.divisor);
  assign cnt_nxt = (tk.restart || at_end) ? 15'h0000 : cnt_r + 15'h0001;
  assign tk.tick = at_end && !tk.restart;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 15'h0000;
    else cnt_r <= cnt_nxt;
  end
endmodule

// file: logic/sptx_top.sv
// serial port transmitter with receive word view and shared control
`timescale 1ns/1ns
module sptx_top (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // register port
  input wire logic [8:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  // receiver side status and data
  input wire logic [8:0] RX_DATA,
  input wire logic RX_STOP,
  input wire logic RX_FULL,
  input wire logic RX_OVERRUN,
  input wire logic RXD_PIN,
  output logic RX_NINE_BITS,
  output logic [14:0] BAUD_DIVISOR,
  // line and events
  output logic TXD,
  output logic TX_HOLDING_EMPTY_PULSE,
  output logic TX_SHIFTER_EMPTY
);
  sptx_tick_if tk();
  sptx_pkg::sptx_state_t state_r;
  sptx_pkg::sptx_state_t state_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] baud_r;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic hold_full_r;
  logic hold_full_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic out_bit_r;
  logic out_bit_nxt;
  logic tbe_pulse_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] baud_nxt;
  logic tbe_pulse_nxt;
  logic [15:0] rx_word;

  // one step of the shifter: zeros fill from the top
  function automatic logic [15:0] shift_down(input logic [15:0] v);
    shift_down = {1'b0, v[15:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (sptx_pkg::BAUD_W != 15) begin : g_bad_width
    $error("divisor width must match the bit timer");
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode
  wire logic wr_ctrl = REG_WR && (REG_ADDR == sptx_pkg::ADDR_CTRL);
  wire logic wr_baud = REG_WR && (REG_ADDR == sptx_pkg::ADDR_BAUD);
  wire logic wr_tx = REG_WR && (REG_ADDR == sptx_pkg::ADDR_TX_WORD);
  wire logic rd_rx = REG_RD && (REG_ADDR == sptx_pkg::ADDR_RX_WORD);
  wire logic tx_nonzero = (REG_WDATA != 16'h0000);
  wire logic [15:0] ctrl_mask = {1'b0, REG_WDATA[14:0]};
  wire logic brk = ctrl_r[sptx_pkg::BIT_BREAK];

  // set or clear only the bits written as one
  wire logic [15:0] ctrl_set = ctrl_r | ctrl_mask;
  wire logic [15:0] ctrl_clr = ctrl_r & ~ctrl_mask;
  wire logic set_sel = REG_WDATA[sptx_pkg::BIT_SETCLR];

  assign ctrl_nxt = !wr_ctrl ? ctrl_r : set_sel ? ctrl_set : ctrl_clr;
  assign baud_nxt = wr_baud ? REG_WDATA : baud_r;

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencing
  wire logic idle = (state_r == sptx_pkg::SPTX_IDLE);
  wire logic load = idle && hold_full_r;
  wire logic done = (shift_r == 16'h0000) && out_bit_r;
  wire logic holding_empty = !hold_full_r;

  assign tk.divisor = baud_r[sptx_pkg::BAUD_W-1:0];
  assign tk.restart = load;

  ////////////////////////////////////////////////////////////////////////
  // shifter state machine
  // start bit first, then data from bit 0 upward
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    out_bit_nxt = out_bit_r;
    unique case (state_r)
      sptx_pkg::SPTX_IDLE: begin
        if (load) begin
          shift_nxt = hold_r;
          out_bit_nxt = 1'b0;
          state_nxt = sptx_pkg::SPTX_START;
        end
      end
      sptx_pkg::SPTX_START: begin
        if (tk.tick) begin
          out_bit_nxt = shift_r[0];
          shift_nxt = shift_down(shift_r);
          state_nxt = sptx_pkg::SPTX_SHIFT;
        end
      end
      sptx_pkg::SPTX_SHIFT: begin
        if (tk.tick) begin
          if (done) begin
            state_nxt = sptx_pkg::SPTX_IDLE;
          end else begin
            out_bit_nxt = shift_r[0];
            shift_nxt = shift_down(shift_r);
          end
        end
      end
      default: begin
        state_nxt = sptx_pkg::SPTX_IDLE;
      end
    endcase
  end

  // holding register: a write with data starts sending on its own
  assign hold_nxt = (wr_tx && tx_nonzero) ? REG_WDATA : hold_r;
  assign hold_full_nxt = (wr_tx && tx_nonzero) ? 1'b1 :
                         load ? 1'b0 : hold_full_r;
  assign tbe_pulse_nxt = load;

  // line rests at mark whenever the shifter goes idle and break is clear
  wire logic out_bit_d = (state_nxt == sptx_pkg::SPTX_IDLE) ? 1'b1 : out_bit_nxt;

  ////////////////////////////////////////////////////////////////////////
  // receive word view
  // status bits on top, received data below
  wire logic nine_mode = baud_r[sptx_pkg::BIT_NINE];
  wire logic rx_bit8 = nine_mode ? RX_DATA[8] : RX_STOP;
  wire logic [7:0] rx_low_byte = RX_DATA[7:0];
  wire logic shifter_empty = idle && !hold_full_r;

  assign rx_word[15] = RX_OVERRUN;
  assign rx_word[14] = RX_FULL;
  assign rx_word[13] = holding_empty;
  assign rx_word[12] = shifter_empty;
  assign rx_word[11] = RXD_PIN;
  assign rx_word[10:9] = 2'h0;
  assign rx_word[8] = rx_bit8;
  assign rx_word[7:0] = rx_low_byte;

  // captured on the read strobe, held until the next read
  assign rdata_nxt = rd_rx ? rx_word : rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= sptx_pkg::SPTX_IDLE;
      ctrl_r <= sptx_pkg::CTRL_RESET;
      baud_r <= sptx_pkg::BAUD_RESET;
      hold_r <= 16'h0000;
      hold_full_r <= 1'b0;
      shift_r <= 16'h0000;
      out_bit_r <= 1'b1;
      tbe_pulse_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      baud_r <= baud_nxt;
      hold_r <= hold_nxt;
      hold_full_r <= hold_full_nxt;
      shift_r <= shift_nxt;
      out_bit_r <= out_bit_d;
      tbe_pulse_r <= tbe_pulse_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit interval timer
  sptx_bit_timer u_timer (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign TXD = brk ? 1'b0 : out_bit_r;
  assign TX_HOLDING_EMPTY_PULSE = tbe_pulse_r;
  assign TX_SHIFTER_EMPTY = idle && !hold_full_r;
  assign REG_RDATA = rdata_r;
  assign RX_NINE_BITS = baud_r[sptx_pkg::BIT_NINE];
  assign BAUD_DIVISOR = baud_r[sptx_pkg::BAUD_W-1:0];
endmodule

// file: sim/sptx_asserts.sv
// port assertions for the serial transmitter
`timescale 1ns/1ns
module sptx_asserts (
  input wire logic SYS_CLK, RSTN, REG_WR, REG_RD,
  input wire logic [8:0] REG_ADDR, RX_DATA,
  input wire logic [15:0] REG_WDATA, REG_RDATA,
  input wire logic RX_STOP, RX_NINE_BITS, TXD, TX_HOLDING_EMPTY_PULSE, TX_SHIFTER_EMPTY,
  input wire logic [14:0] BAUD_DIVISOR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire wtx = REG_WR && REG_ADDR == sptx_pkg::ADDR_TX_WORD && TX_SHIFTER_EMPTY;
  wire wct = REG_WR && REG_ADDR == sptx_pkg::ADDR_CTRL;
  wire rrx = REG_RD && REG_ADDR == sptx_pkg::ADDR_RX_WORD;
  logic [15:0] run_r;
  always_ff @(posedge SYS_CLK) run_r <= $changed(TXD) ? 16'h0001 : run_r + 16'h0001;
  zero_word_a: assert property (wtx && REG_WDATA == 16'h0000
    |=> TX_SHIFTER_EMPTY) else $error("zero word sent");
  write_start_a: assert property (wtx && |REG_WDATA |-> ##[1:2] !TX_SHIFTER_EMPTY)
    else $error("write did not start");
  start_bit_a: assert property (wtx && TXD && |REG_WDATA |-> ##[1:3] !TXD)
    else $error("no start bit");
  load_pulse_a: assert property (wtx && |REG_WDATA |-> ##[1:3] TX_HOLDING_EMPTY_PULSE)
    else $error("no load pulse");
  bit_time_a: assert property ($rose(TXD) && !TX_SHIFTER_EMPTY
    |-> run_r % (BAUD_DIVISOR + 15'h0001) == 16'h0000) else $error("bit time wrong");
  break_low_a: assert property (wct && REG_WDATA[15] && REG_WDATA[11] |=> !TXD)
    else $error("break not low");
  break_clear_a: assert property (wct && !REG_WDATA[15] && REG_WDATA[11] && TX_SHIFTER_EMPTY
    |=> TXD) else $error("break not cleared");
  rx_low_a: assert property (rrx |=> REG_RDATA[7:0] == $past(RX_DATA[7:0]))
    else $error("rx byte wrong");
  rx_bit8_a: assert property (rrx |=> REG_RDATA[8] ==
    ($past(RX_NINE_BITS) ? $past(RX_DATA[8]) : $past(RX_STOP))) else $error("rx bit 8 wrong");
  cover property (wtx && |REG_WDATA);
  cover property ($rose(TX_SHIFTER_EMPTY));
  cover property (wct && REG_WDATA[11]);
endmodule

// file: sim/sptx_remote.sv
// remote receiver on the line, echoing it back
`timescale 1ns/1ns
module sptx_remote (
  input wire logic clk, txd,
  input wire logic [14:0] div,
  output logic rxd, done,
  output logic [10:0] word
);
  initial begin
    {done, word} = 12'h000;
    forever begin
      @(negedge txd);
      repeat (div / 2 + 1) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
        if (i > 0) repeat (div + 1) @(posedge clk);
        word[i] = txd;
      end
      done = 1'b1;
      @(posedge clk) done = 1'b0;
    end
  end
  always @(posedge clk) rxd <= txd;
endmodule

// file: sim/tb_top.sv
// self-checking bench for the serial transmitter
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
  logic SYS_CLK, RSTN, REG_WR, REG_RD, RX_STOP, RX_FULL, RX_OVERRUN, RXD_PIN, done;
  logic TXD, RX_NINE_BITS, TX_HOLDING_EMPTY_PULSE, TX_SHIFTER_EMPTY;
  logic [8:0] REG_ADDR, RX_DATA;
  logic [15:0] REG_WDATA, REG_RDATA, w;
  logic [14:0] BAUD_DIVISOR;
  logic [10:0] word, f;
  logic [10:0] q[$];
  int failures = 0;
  int check_count = 0;
  sptx_top dut_u (.*);
  sptx_remote rem_u (.clk(SYS_CLK), .txd(TXD), .div(BAUD_DIVISOR), .rxd(RXD_PIN),
    .done(done), .word(word));
  task automatic acc(input logic [8:0] a, input logic [15:0] d, input logic rd);
    @(posedge SYS_CLK);
    {REG_ADDR, REG_WDATA, REG_WR, REG_RD} <= {a, d, !rd, rd};
    @(posedge SYS_CLK);
    {REG_WR, REG_RD} <= 2'b00;
  endtask
  task automatic finish_test();
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge done) begin
    if (q.size() > 0) begin
      f = q.pop_front();
      `CHK("frame", f, word)
    end else begin
      failures++;
      $display("mismatch frame exp none got %h", word);
    end
  end
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    #100000 failures++;
    finish_test();
  end
  initial begin
    {RSTN, REG_WR, REG_RD, RX_STOP, RX_FULL, RX_OVERRUN, REG_ADDR, RX_DATA, REG_WDATA} = '0;
    void'($urandom(35));
    repeat (12) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    for (int n = 0; n < 2; n++) begin
      acc(sptx_pkg::ADDR_BAUD, {n[0], 15'h0003}, 1'b0);
      {RX_OVERRUN, RX_FULL, RX_STOP, RX_DATA} <= 12'($urandom);
      acc(sptx_pkg::ADDR_RX_WORD, 16'h0000, 1'b1);
      #1 `CHK("rx", {RX_OVERRUN, RX_FULL, 5'h1C,
        n[0] ? RX_DATA[8] : RX_STOP, RX_DATA[7:0]}, REG_RDATA)
    end
    for (int k = 0; k < 3; k++) begin
      w = {8'h03, 8'($urandom)};
      q.push_back({w[9:0], 1'b0});
      acc(sptx_pkg::ADDR_TX_WORD, w, 1'b0);
      w = {8'h01, 8'($urandom)};
      q.push_back({1'b1, w[8:0], 1'b0});
      acc(sptx_pkg::ADDR_TX_WORD, w, 1'b0);
      acc(sptx_pkg::ADDR_CTRL, 16'h0000, 1'b0);
      acc(sptx_pkg::ADDR_TX_WORD, 16'h0000, 1'b0);
      repeat (120) @(posedge SYS_CLK);
      `CHK("sent", 0, q.size())
      `CHK("idle", 1'b1, TX_SHIFTER_EMPTY)
      acc(sptx_pkg::ADDR_TX_WORD, 16'h0000, 1'b0);
      repeat (2) @(posedge SYS_CLK);
      `CHK("zero", 1'b1, TX_SHIFTER_EMPTY)
    end
    acc(sptx_pkg::ADDR_CTRL, 16'h8800, 1'b0);
    acc(sptx_pkg::ADDR_CTRL, 16'h8000, 1'b0);
    #1 `CHK("break", 1'b0, TXD)
    acc(sptx_pkg::ADDR_CTRL, 16'h0800, 1'b0);
    #1 `CHK("mark", 1'b1, TXD)
    finish_test();
  end
endmodule
bind sptx_top sptx_asserts chk_u (.*);
